// *** serial_flash_spi_protocol_select_bench.sv ***
`timescale 1ns/100ps
module serial_flash_spi_protocol_select_bench;
  import sfps_pkg::*;
  logic        sys_clk;
  logic        arst_n;
  logic        vpp_high;
  logic [15:0] nv_cfg;
  logic        pe_busy;
  logic        rescue;
  logic        tx_en;
  logic [3:0]  host_dq;
  logic [3:0]  pin_dq;
  logic        sclk;
  logic        cs_n;
  logic [3:0]  dq_out;
  logic [3:0]  dq_oe_n;
  sfps_proto_t protocol;
  logic [15:0] work_cfg;
  logic [7:0]  vcfg;
  logic [7:0]  evcfg;
  logic [15:0] nv_wr_data;
  logic        nv_wr_stb;
  logic        cmd_drop;
  logic [7:0]  cap;
  logic [15:0] nv_seen;
  logic [7:0]  rx_byte;
  logic        rx_valid;
  logic        tx_req;
  logic [7:0]  rx_seen;
  sfps_proto_t ext_lanes;
  logic [2:0]  op_ln;
  int          n_txreq;
  int          n_drop;
  int          miscompares;
  int          n_checks;

  // System clock
  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;

  // Each line shows the device while it drives, else the host
  assign pin_dq = (~dq_oe_n & dq_out) | (dq_oe_n & host_dq);

  sfps_host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_dq(host_dq), .i_pin(pin_dq),
                        .i_dq_oe_n(dq_oe_n), .i_op_ln(op_ln), .o_cap(cap));

  sfps_core dut (
    .i_sys_clk(sys_clk), .i_arst_n(arst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_dq(pin_dq),
    .i_vpp_high(vpp_high), .i_nv_cfg(nv_cfg), .i_ext_lanes(ext_lanes), .i_pe_busy(pe_busy),
    .i_rescue(rescue), .i_tx_en(tx_en), .i_tx_byte(8'hA5), .o_dq_out(dq_out),
    .o_dq_oe_n(dq_oe_n), .o_protocol(protocol), .o_work_cfg(work_cfg), .o_vcfg(vcfg),
    .o_evcfg(evcfg), .o_rx_byte(rx_byte), .o_rx_valid(rx_valid), .o_tx_req(tx_req),
    .o_nv_wr_data(nv_wr_data),
    .o_nv_wr_stb(nv_wr_stb), .o_cmd_drop(cmd_drop));

  // Pulse watchers
  always @(posedge sys_clk) begin
    if (cmd_drop === 1'b1) n_drop++;
    if (nv_wr_stb === 1'b1) nv_seen <= nv_wr_data;
    if (rx_valid === 1'b1) rx_seen <= rx_byte;
    if (tx_req === 1'b1) n_txreq++;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chkp(input sfps_proto_t exp);
    chk(16'(protocol), 16'(exp));
  endtask : chkp

  task automatic settle;
    repeat (8) @(posedge sys_clk);
    #1;
  endtask : settle

  task automatic boot(input logic [15:0] nv);
    @(posedge sys_clk);
    nv_cfg <= nv;
    arst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    settle;
  endtask : boot

  task automatic wr_ev(input logic cpol, input int ln, input logic [7:0] v);
    host.frame(cpol, ln, {OP_WR_EVCFG, v, 8'h00}, 16);
  endtask : wr_ev

  // Power-on protocol and working configuration per nonvolatile setting
  task automatic t_boot;
    logic [15:0] nvt [3];
    sfps_proto_t prt [3];
    nvt = '{16'hFFFF, 16'hFFF7, 16'hFFFB};
    prt = '{PR_EXT, PR_QUAD, PR_DUAL};
    for (int i = 0; i < 3; i++) begin
      boot(nvt[i]);
      chkp(prt[i]);
      chk(work_cfg, nvt[i]);
      chk(16'(dq_oe_n), 16'h000F);
    end
  endtask : t_boot

  // Volatile switching through all protocols, both clock modes
  task automatic t_volatile;
    boot(16'hFFFF);
    wr_ev(1'b0, 1, 8'h3F);
    @(posedge sys_clk);
    #1;
    chkp(PR_EXT);
    settle;
    chkp(PR_QUAD);
    chk(16'(evcfg), 16'h003F);
    chk(16'(work_cfg[7:0]), 16'h003F);
    wr_ev(1'b1, 4, 8'hBF);
    settle;
    chkp(PR_DUAL);
    wr_ev(1'b0, 2, 8'hFF);
    settle;
    chkp(PR_EXT);
    host.frame(1'b1, 1, {OP_WR_VCFG, 8'h5A, 8'h00}, 16);
    settle;
    chk(16'(vcfg), 16'h005A);
    chk(16'(work_cfg[15:8]), 16'h005A);
    chk(16'(rx_seen), 16'h005A);
  endtask : t_volatile

  // Partial byte write is dropped
  task automatic t_drop;
    int n0;
    n0 = n_drop;
    wr_ev(1'b0, 1, 8'h3F);
    settle;
    n0 = n_drop;
    host.frame(1'b0, 4, {OP_WR_EVCFG, 8'hFF, 8'h00}, 12);
    settle;
    chk(16'(n_drop - n0), 16'h0001);
    chkp(PR_QUAD);
  endtask : t_drop

  // Rescue and high-voltage fallback
  task automatic t_fallback;
    @(posedge sys_clk);
    pe_busy  <= 1'b1;
    vpp_high <= 1'b1;
    settle;
    chkp(PR_EXT);
    @(posedge sys_clk);
    vpp_high <= 1'b0;
    settle;
    chkp(PR_QUAD);
    @(posedge sys_clk);
    pe_busy <= 1'b0;
    rescue  <= 1'b1;
    @(posedge sys_clk);
    rescue <= 1'b0;
    settle;
    chkp(PR_EXT);
  endtask : t_fallback

  // Nonvolatile write acts only at the next power-on
  task automatic t_nv;
    boot(16'hFFFF);
    host.frame(1'b0, 1, {OP_WR_NVCFG, 8'hF7, 8'hFF}, 24);
    settle;
    chk(nv_seen, 16'hFFF7);
    chkp(PR_EXT);
    boot(nv_seen);
    chkp(PR_QUAD);
    chk(work_cfg, 16'hFFF7);
  endtask : t_nv

  // Device output on the single line, both clock modes
  task automatic t_tx;
    int n0;
    boot(16'hFFFF);
    @(posedge sys_clk);
    tx_en <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      n0 = n_txreq;
      host.frame(m[0], 1, 24'h0B0000, 9);
      settle;
      chk(16'(cap), 16'h00A5);
      chk(16'(n_txreq - n0), 16'(2 - m));
      chk(16'(dq_oe_n), 16'h000F);
    end
    @(posedge sys_clk);
    tx_en <= 1'b0;
  endtask : t_tx

  // Extended protocol, opcode on line 0, four-line body
  task automatic t_ext;
    boot(16'hFFFF);
    @(posedge sys_clk);
    ext_lanes <= PR_QUAD;
    op_ln     <= 3'h1;
    host.frame(1'b0, 4, {OP_WR_VCFG, 8'hC3, 8'h00}, 16);
    settle;
    chk(16'(vcfg), 16'h00C3);
    chkp(PR_EXT);
    @(posedge sys_clk);
    ext_lanes <= PR_EXT;
    op_ln     <= 3'h0;
  endtask : t_ext

  task automatic report_and_stop;
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // Watchdog
  initial begin
    #2000000;
    miscompares++;
    report_and_stop;
  end

  // Main sequence
  initial begin
    arst_n   = 1'b0;
    vpp_high = 1'b0;
    nv_cfg   = 16'hFFFF;
    pe_busy  = 1'b0;
    rescue   = 1'b0;
    tx_en    = 1'b0;
    nv_seen  = 16'h0000;
    rx_seen  = 8'h00;
    ext_lanes = PR_EXT;
    op_ln    = 3'h0;
    t_boot;
    t_volatile;
    t_drop;
    t_fallback;
    t_nv;
    t_tx;
    t_ext;
    report_and_stop;
  end
endmodule : serial_flash_spi_protocol_select_bench

// *** sfps_core.sv ***
`timescale 1ns/100ps
module sfps_core
  import sfps_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_sclk,
  input  wire logic        i_cs_n,
  input  wire logic [3:0]  i_dq,
  input  wire logic        i_vpp_high,
  input  wire logic [15:0] i_nv_cfg,
  input  wire sfps_proto_t i_ext_lanes,
  input  wire logic        i_pe_busy,
  input  wire logic        i_rescue,
  input  wire logic        i_tx_en,
  input  wire logic [7:0]  i_tx_byte,
  output logic [3:0]       o_dq_out,
  output logic [3:0]       o_dq_oe_n,
  output sfps_proto_t      o_protocol,
  output logic [15:0]      o_work_cfg,
  output logic [7:0]       o_vcfg,
  output logic [7:0]       o_evcfg,
  output logic [7:0]       o_rx_byte,
  output logic             o_rx_valid,
  output logic             o_tx_req,
  output logic [15:0]      o_nv_wr_data,
  output logic             o_nv_wr_stb,
  output logic             o_cmd_drop
);

  sfps_link_if lk ();

  sfps_pin_sync u_sync (
    .i_sys_clk  (i_sys_clk),
    .i_arst_n   (i_arst_n),
    .i_sclk     (i_sclk),
    .i_cs_n     (i_cs_n),
    .i_dq       (i_dq),
    .i_vpp_high (i_vpp_high),
    .lk         (lk.src)
  );

  logic        boot_r;
  sfps_phase_t phase_r;
  sfps_proto_t base_proto_r;
  logic        seen_rise_r;
  logic [3:0]  rx_cnt_r;
  logic [3:0]  tx_cnt_r;
  logic [7:0]  rx_sh_r;
  logic [7:0]  tx_sh_r;
  logic [7:0]  opcode_r;
  logic [15:0] data_r;
  logic [1:0]  byte_cnt_r;

  // Protocol selection
  sfps_proto_t eff_proto;
  sfps_proto_t nv_proto;
  sfps_proto_t ev_proto;
  logic [3:0]  cur_lanes;
  assign eff_proto = (base_proto_r == PR_QUAD && lk.vpp_high && i_pe_busy)
                     ? PR_EXT : base_proto_r; // RULE11
  assign nv_proto  = !i_nv_cfg[NV_QUADN_BIT] ? PR_QUAD :
                     (!i_nv_cfg[NV_DUALN_BIT] ? PR_DUAL : PR_EXT); // RULE9 RULE10 RULE14
  assign ev_proto  = !data_r[8+EV_QUADN_BIT] ? PR_QUAD :
                     (!data_r[8+EV_DUALN_BIT] ? PR_DUAL : PR_EXT); // RULE6 RULE7 RULE16
  assign cur_lanes = (phase_r == PH_BODY && eff_proto == PR_EXT)
                     ? sfps_lanes(i_ext_lanes) : sfps_lanes(eff_proto); // RULE5 RULE3

  // Edge qualification inside a frame
  logic in_frame;
  logic rx_go;
  logic tx_go;
  assign in_frame = lk.cs_act && (phase_r != PH_IDLE); // RULE4
  assign rx_go    = in_frame && lk.sclk_rise; // RULE2
  assign tx_go    = in_frame && lk.sclk_fall && seen_rise_r; // RULE1 RULE2

  // Receive shifter
  logic [3:0] rx_sum;
  logic       rx_done;
  logic [7:0] rx_sh_nxt;
  assign rx_sum    = rx_cnt_r + cur_lanes;
  assign rx_done   = rx_go && rx_sum[3];
  assign rx_sh_nxt = (cur_lanes == 4'h4) ? {rx_sh_r[3:0], lk.dq_in} :
                     ((cur_lanes == 4'h2) ? {rx_sh_r[5:0], lk.dq_in[1:0]} :
                                            {rx_sh_r[6:0], lk.dq_in[0]});

  // Register write qualification at deselect
  logic frame_ok;
  logic is_wr_op;
  logic wr_v;
  logic wr_ev;
  logic wr_nv;
  logic wr_drop;
  assign frame_ok = (phase_r == PH_BODY) && (rx_cnt_r == 4'h0); // RULE15
  assign is_wr_op = (opcode_r == OP_WR_VCFG) || (opcode_r == OP_WR_EVCFG) ||
                    (opcode_r == OP_WR_NVCFG);
  assign wr_v     = lk.cs_end && frame_ok && opcode_r == OP_WR_VCFG
                    && byte_cnt_r == VCFG_BYTES; // RULE18
  assign wr_ev    = lk.cs_end && frame_ok && opcode_r == OP_WR_EVCFG
                    && byte_cnt_r == VCFG_BYTES; // RULE18
  assign wr_nv    = lk.cs_end && frame_ok && opcode_r == OP_WR_NVCFG
                    && byte_cnt_r == NVCFG_BYTES;
  assign wr_drop  = lk.cs_end && (phase_r == PH_BODY) && is_wr_op
                    && !(wr_v || wr_ev || wr_nv);

  // Transmit shifter
  logic [7:0] tx_src;
  logic [3:0] tx_sum;
  logic [3:0] tx_bits;
  logic [3:0] oe_mask;
  logic [7:0] tx_sh_nxt;
  assign tx_src    = (tx_cnt_r == 4'h0) ? i_tx_byte : tx_sh_r;
  assign tx_sum    = tx_cnt_r + cur_lanes;
  assign tx_bits   = (cur_lanes == 4'h4) ? tx_src[7:4] :
                     ((cur_lanes == 4'h2) ? {2'b00, tx_src[7:6]} : {2'b00, tx_src[7], 1'b0});
  assign oe_mask   = (cur_lanes == 4'h4) ? 4'hF : ((cur_lanes == 4'h2) ? 4'h3 : 4'h2);
  assign tx_sh_nxt = (cur_lanes == 4'h4) ? {tx_src[3:0], 4'h0} :
                     ((cur_lanes == 4'h2) ? {tx_src[5:0], 2'b00} : {tx_src[6:0], 1'b0});

  // Boot marker, low only in the first cycle after reset release
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      boot_r <= 1'b0;
    end else begin
      boot_r <= 1'b1;
    end
  end

  // Frame phase
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      phase_r <= PH_IDLE;
    end else if (lk.cs_start) begin
      phase_r <= PH_OPC;
    end else if (lk.cs_end) begin
      phase_r <= PH_IDLE;
    end else if (rx_done && phase_r == PH_OPC) begin
      phase_r <= PH_BODY;
    end
  end

  // Active protocol: boot load, rescue, volatile write
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      base_proto_r <= PR_EXT; // RULE5
    end else if (!boot_r) begin
      base_proto_r <= nv_proto; // RULE9 RULE10
    end else if (i_rescue) begin
      base_proto_r <= PR_EXT; // RULE8
    end else if (wr_ev) begin
      base_proto_r <= ev_proto; // RULE6 RULE7 RULE8
    end
  end

  // Working and volatile configuration
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_work_cfg <= WCFG_RST;
      o_vcfg     <= VCFG_RST;
      o_evcfg    <= EVCFG_RST;
    end else if (!boot_r) begin
      o_work_cfg <= i_nv_cfg; // RULE12
    end else if (wr_v) begin
      o_work_cfg[15:8] <= data_r[15:8]; // RULE13
      o_vcfg           <= data_r[15:8];
    end else if (wr_ev) begin
      o_work_cfg[7:0] <= data_r[15:8]; // RULE13
      o_evcfg         <= data_r[15:8];
    end
  end

  // Receive path
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_cnt_r    <= 4'h0;
      rx_sh_r     <= 8'h00;
      opcode_r    <= 8'h00;
      data_r      <= 16'h0000;
      byte_cnt_r  <= 2'h0;
      seen_rise_r <= 1'b0;
    end else if (lk.cs_start) begin
      rx_cnt_r    <= 4'h0;
      byte_cnt_r  <= 2'h0;
      opcode_r    <= 8'h00;
      seen_rise_r <= 1'b0; // RULE1
    end else if (rx_go) begin
      rx_sh_r     <= rx_sh_nxt;
      rx_cnt_r    <= rx_done ? 4'h0 : rx_sum;
      seen_rise_r <= 1'b1;
      if (rx_done && phase_r == PH_OPC) begin
        opcode_r <= rx_sh_nxt;
      end
      if (rx_done && phase_r == PH_BODY) begin
        data_r     <= {rx_sh_nxt, data_r[15:8]};
        byte_cnt_r <= (byte_cnt_r == 2'h3) ? byte_cnt_r : byte_cnt_r + 2'h1;
      end
    end
  end

  // Received byte strobe
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rx_byte  <= 8'h00;
      o_rx_valid <= 1'b0;
    end else begin
      o_rx_valid <= rx_done;
      if (rx_done) begin
        o_rx_byte <= rx_sh_nxt;
      end
    end
  end

  // Transmit path, shifts on falling edges only
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_cnt_r <= 4'h0;
      tx_sh_r  <= 8'h00;
      o_dq_out <= 4'h0;
      o_tx_req <= 1'b0;
    end else if (lk.cs_start) begin
      tx_cnt_r <= 4'h0;
      o_tx_req <= 1'b0;
    end else if (tx_go) begin
      o_dq_out <= tx_bits; // RULE2
      tx_sh_r  <= tx_sh_nxt;
      tx_cnt_r <= tx_sum[3] ? 4'h0 : tx_sum;
      o_tx_req <= (tx_cnt_r == 4'h0);
    end else begin
      o_tx_req <= 1'b0;
    end
  end

  // Output enables, low only while selected and sending
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_dq_oe_n <= 4'hF;
    end else begin
      o_dq_oe_n <= (in_frame && i_tx_en) ? ~oe_mask : 4'hF; // RULE4
    end
  end

  // Status strobes and effective protocol
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_protocol   <= PR_EXT;
      o_nv_wr_stb  <= 1'b0;
      o_nv_wr_data <= 16'h0000;
      o_cmd_drop   <= 1'b0;
    end else begin
      o_protocol  <= eff_proto; // RULE11
      o_nv_wr_stb <= wr_nv; // RULE15
      o_cmd_drop  <= wr_drop;
      if (wr_nv) begin
        o_nv_wr_data <= data_r;
      end
    end
  end

  // Checks
  property p_desel_release;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      !lk.cs_act |=> o_dq_oe_n == 4'hF;
  endproperty
  a_desel_release: assert property (p_desel_release) // RULE4
    else $error("Data line driven while deselected");

  property p_boot_load;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      $rose(boot_r) |-> o_work_cfg == $past(i_nv_cfg);
  endproperty
  a_boot_load: assert property (p_boot_load) // RULE12
    else $error("Working configuration not loaded at boot");

  property p_boot_quad;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      $rose(boot_r) && !$past(i_nv_cfg[3]) |-> base_proto_r == PR_QUAD;
  endproperty
  a_boot_quad: assert property (p_boot_quad) // RULE10
    else $error("Boot did not select quad");

  property p_boot_dual;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      $rose(boot_r) && $past(i_nv_cfg[3:2]) == 2'b10 |-> base_proto_r == PR_DUAL;
  endproperty
  a_boot_dual: assert property (p_boot_dual) // RULE9
    else $error("Boot did not select dual");

  property p_boot_ext;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      $rose(boot_r) && $past(i_nv_cfg[3:2]) == 2'b11 |-> base_proto_r == PR_EXT;
  endproperty
  a_boot_ext: assert property (p_boot_ext) // RULE14
    else $error("Boot left extended protocol");

  property p_change_cause;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      $changed(base_proto_r) |-> $rose(boot_r) || $past(lk.cs_end) || $past(i_rescue);
  endproperty
  a_change_cause: assert property (p_change_cause) // RULE18
    else $error("Protocol changed outside deselect");

  property p_ev_quad;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      wr_ev && !i_rescue && !data_r[15] |=> base_proto_r == PR_QUAD ##1 o_protocol != PR_DUAL;
  endproperty
  a_ev_quad: assert property (p_ev_quad) // RULE7
    else $error("Volatile quad selection failed");

  property p_ev_dual;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      wr_ev && !i_rescue && data_r[15:14] == 2'b10 |=> base_proto_r == PR_DUAL;
  endproperty
  a_ev_dual: assert property (p_ev_dual) // RULE6
    else $error("Volatile dual selection failed");

  property p_partial_byte;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      lk.cs_end && rx_cnt_r != 4'h0 |=> !o_nv_wr_stb && $stable(o_vcfg) && $stable(o_evcfg);
  endproperty
  a_partial_byte: assert property (p_partial_byte) // RULE15
    else $error("Write executed on partial byte");

  property p_vpp_fallback;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      base_proto_r == PR_QUAD && lk.vpp_high && i_pe_busy |=> o_protocol == PR_EXT;
  endproperty
  a_vpp_fallback: assert property (p_vpp_fallback) // RULE11
    else $error("No extended fallback during high-supply program");

  property p_vcfg_copy;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      wr_v |=> o_work_cfg[15:8] == $past(data_r[15:8]) && o_vcfg == $past(data_r[15:8]);
  endproperty
  a_vcfg_copy: assert property (p_vcfg_copy) // RULE13
    else $error("Volatile write not copied to working configuration");

  property p_out_on_fall;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      $changed(o_dq_out) |-> $past(lk.sclk_fall) && $past(seen_rise_r);
  endproperty
  a_out_on_fall: assert property (p_out_on_fall) // RULE2 RULE1 RULE3
    else $error("Output changed off a falling edge");

endmodule : sfps_core

// *** sfps_host_model.sv ***
`timescale 1ns/100ps
// Behavioural host that drives clock, select and data lines of the serial bus
module sfps_host_model (
  output logic            o_sclk,
  output logic            o_cs_n,
  output logic [3:0]      o_dq,
  input  wire logic [3:0] i_pin,
  input  wire logic [3:0] i_dq_oe_n,
  input  wire logic [2:0] i_op_ln,
  output logic [7:0]      o_cap
);
  // Idle bus: deselected, clock low
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_dq   = 4'h5;
    o_cap  = 8'h00;
  end

  // Host samples the single output line on rising clock edges
  always @(posedge o_sclk) begin
    if (!o_cs_n && !i_dq_oe_n[1]) begin
      o_cap <= {o_cap[6:0], i_pin[1]};
    end
  end

  // One framed command, high bits first, ln lines per clock
  // Opcode bits use i_op_ln lines instead when it is not zero
  task automatic frame(input logic cpol, input int ln, input logic [23:0] d, input int nb);
    int i;
    int k;
    int w;
    #37;
    o_sclk = cpol;
    #400 o_cs_n = 1'b0;
    i = 0;
    while (i < nb) begin
      w = (i < 8 && i_op_ln != 3'h0) ? int'(i_op_ln) : ln;
      #400 o_sclk = 1'b0;
      for (k = 0; k < w; k++) o_dq[w-1-k] = d[23-i-k];
      #400 o_sclk = 1'b1;
      i += w;
    end
    #400 o_sclk = cpol;
    #400 o_cs_n = 1'b1;
    o_dq = ~o_dq; // Released lines stop showing the old value
  endtask : frame
endmodule : sfps_host_model

// *** sfps_link_if.sv ***
`timescale 1ns/100ps
// Synchronised pin events from the sampler to the protocol core
interface sfps_link_if;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_act;
  logic       cs_start;
  logic       cs_end;
  logic       vpp_high;
  logic [3:0] dq_in;

  modport src (output sclk_rise, sclk_fall, cs_act, cs_start, cs_end, vpp_high, dq_in);
  modport snk (input  sclk_rise, sclk_fall, cs_act, cs_start, cs_end, vpp_high, dq_in);
endinterface : sfps_link_if

// *** sfps_pin_sync.sv ***
`timescale 1ns/100ps
module sfps_pin_sync
  import sfps_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_sclk,
  input  wire logic       i_cs_n,
  input  wire logic [3:0] i_dq,
  input  wire logic       i_vpp_high,
  sfps_link_if.src        lk
);

  logic [6:0] meta_r;
  logic [6:0] sync_r;
  logic       sclk_d_r;
  logic       cs_n_d_r;

  // Two-stage synchroniser for all pins
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_r <= PIN_RST;
      sync_r <= PIN_RST;
    end else begin
      meta_r <= {i_vpp_high, i_dq, i_cs_n, i_sclk};
      sync_r <= meta_r;
    end
  end

  // Delayed copies for edge detection
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sclk_d_r <= 1'b0;
      cs_n_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sync_r[0];
      cs_n_d_r <= sync_r[1];
    end
  end

  // Edge events, valid for one system clock, plus synchronised select, data and supply levels
  assign lk.sclk_rise = sync_r[0] & ~sclk_d_r;
  assign lk.sclk_fall = ~sync_r[0] & sclk_d_r;
  assign lk.cs_act    = ~sync_r[1];
  assign lk.cs_start  = ~sync_r[1] & cs_n_d_r;
  assign lk.cs_end    = sync_r[1] & ~cs_n_d_r;
  assign lk.dq_in     = sync_r[5:2];
  assign lk.vpp_high  = sync_r[6];

endmodule : sfps_pin_sync

// *** sfps_pkg.sv ***
// What this block does
// RULE1: Works with serial clock idling low (mode 0) or idling high (mode 3).
// RULE2: Input bits captured on rising clock edges, output bits changed on falling edges.
// RULE3: Both clock modes behave identically in extended, dual and quad protocol.
// RULE4: Data lines are driven only while chip select is active; otherwise released.
// RULE5: Default protocol is extended; opcode arrives on line 0 only.
// RULE6: Volatile write with bit 7 set and bit 6 clear selects dual protocol.
// RULE7: Volatile write with bit 7 clear selects quad protocol.
// RULE8: Volatile protocol lasts until power-on, rescue, or another volatile write.
// RULE9: Nonvolatile bit 2 cleared makes every power-on start in dual protocol.
// RULE10: Nonvolatile bit 3 cleared makes every power-on start in quad protocol.
// RULE11: Quad falls back to extended while program or erase runs with high supply.
// RULE12: Working configuration loads from nonvolatile configuration at every boot.
// RULE13: Volatile register writes copy new settings into working configuration at once.
// RULE14: Nonvolatile quad-enable bit defaults to one, meaning quad disabled.
// RULE15: Register writes execute only if clocked bits form whole bytes.
// RULE16: When quad and dual selections are both active, quad wins.
// RULE17: Host deselects between commands and idles the clock while deselected.
// RULE18: Protocol change from a register write applies at chip select release.
package sfps_pkg;

  // Command protocol, one-hot
  typedef enum logic [2:0] {
    PR_EXT  = 3'b001,
    PR_DUAL = 3'b010,
    PR_QUAD = 3'b100
  } sfps_proto_t;

  // Frame phase, one-hot
  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_OPC  = 3'b010,
    PH_BODY = 3'b100
  } sfps_phase_t;

  // Register write opcodes
  localparam logic [7:0]  OP_WR_VCFG   = 8'h81;
  localparam logic [7:0]  OP_WR_EVCFG  = 8'h61;
  localparam logic [7:0]  OP_WR_NVCFG  = 8'hB1;

  // Field positions
  localparam int          EV_DUALN_BIT = 6;
  localparam int          EV_QUADN_BIT = 7;
  localparam int          NV_DUALN_BIT = 2;
  localparam int          NV_QUADN_BIT = 3;

  // Values after reset
  localparam logic [15:0] WCFG_RST     = 16'hFFFF;
  localparam logic [7:0]  VCFG_RST     = 8'hFF;
  localparam logic [7:0]  EVCFG_RST    = 8'hFF;
  localparam logic [6:0]  PIN_RST      = 7'h02;

  // Data payload lengths of the write commands, in bytes
  localparam logic [1:0]  VCFG_BYTES   = 2'h1;
  localparam logic [1:0]  NVCFG_BYTES  = 2'h2;

  // Lines used per clock edge in a protocol
  function automatic logic [3:0] sfps_lanes(input sfps_proto_t p);
    return (p == PR_QUAD) ? 4'h4 : ((p == PR_DUAL) ? 4'h2 : 4'h1);
  endfunction : sfps_lanes

endpackage : sfps_pkg
